// File: rtl/ito_pkg.sv
// Purpose: Constants for the integrator, timer and over-current channel.
// Assumes: AHB-Lite word access, one channel.
// Notes: Ratio fields hold the ratio minus one.
package ito_pkg;
  localparam int AHB_DW = 32;
  localparam int AHB_AW = 32;
  localparam int OFF_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SINC_DECIMATION_RATIO = 8'h04;
  localparam logic [7:0] OFF_INTEGRATOR_DECIMATION_RATIO = 8'h08;
  localparam logic [7:0] OFF_COSR = 8'h0C;
  localparam logic [7:0] OFF_UPPER = 8'h10;
  localparam logic [7:0] OFF_LOWER = 8'h14;
  localparam logic [7:0] OFF_DATA = 8'h18;
  localparam logic [7:0] OFF_IHOLD = 8'h1C;
  localparam logic [7:0] OFF_THOLD = 8'h20;
  localparam logic [7:0] OFF_CMP = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_MASK = 8'h2C;
  localparam int CB_EN = 0;
  localparam int CB_TM = 1;
  localparam int CB_INTEGRATOR_MODE_SELECT = 2;
  localparam int CB_BYP = 3;
  localparam int SB_DATA = 0;
  localparam int SB_INT = 1;
  localparam int SB_HI = 2;
  localparam int SB_LO = 3;
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [7:0] RST_SINC_DECIMATION_RATIO = 8'h0F;
  localparam logic [7:0] RST_INTEGRATOR_DECIMATION_RATIO = 8'h3F;
  localparam logic [7:0] RST_COSR = 8'h0F;
  localparam logic [15:0] RST_UPPER = 16'hFFFF;
  localparam logic [15:0] RST_LOWER = 16'h0000;
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [1:0] SINC_ORDER = 2'h2;
  localparam logic [1:0] HTRANS_NSQ = 2'h2;
  typedef enum logic [2:0] {
    ITO_IDLE = 3'b001,
    ITO_RD1 = 3'b010,
    ITO_RD2 = 3'b100
  } ito_bus_e;
endpackage : ito_pkg

// File: rtl/ito_top.sv
// Purpose: One filter channel: sinc2 data path, integrator, timer, trip window.
// Assumes: Modulator clock, bit and sample-hold pins are synchronous to hclk.
// Notes: Registers on AHB-Lite; reads take one wait state.
// Notes on behaviour
// - S/H edge latches sum, count; restarts both.
// - Timer mode and integrator mode run together.
// - Integrator follows sinc filter or replaces it.
// - Bypass sums raw modulator bits directly.
// - High bit adds one, low bit subtracts one.
// - Filter settles after order times ratio periods.
// - Sixteen-bit upper and lower trip levels.
// - Order-two comparator at 16 spans 0..256.
// - Window exit raises fast over-current flag.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ito_top #(
  parameter int SINC_W = 24,
  parameter int ACC_W = 32,
  parameter int TMR_W = 16
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [ito_pkg::AHB_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [ito_pkg::AHB_DW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [ito_pkg::AHB_DW-1:0] hrdata,
  // Modulator side.
  input wire logic modulator_clock_input,
  input wire logic modulator_bit_input,
  input wire logic sample_hold_input,
  // Events.
  output logic overcurrent_flag,
  output logic irq
);
  import ito_pkg::*;

  if (SINC_W < 17 || SINC_W > 32) begin : g_chk_sinc
    $error("SINC_W must be 17 to 32");
  end
  if (ACC_W <= SINC_W || ACC_W > 32) begin : g_chk_acc
    $error("ACC_W must exceed SINC_W and be at most 32");
  end
  if (TMR_W < 2 || TMR_W > 32) begin : g_chk_tmr
    $error("TMR_W must be 2 to 32");
  end

  ito_bus_e st_ff;
  ito_bus_e nxt_st;
  logic wr_ff;
  logic [7:0] daddr_ff;
  logic [3:0] ctrl_ff;
  logic [7:0] sinc_decimation_ratio_ff;
  logic [7:0] integrator_decimation_ratio_ff;
  logic [7:0] cosr_ff;
  logic [15:0] upper_ff;
  logic [15:0] lower_ff;
  logic [3:0] status_ff;
  logic [3:0] mask_ff;
  logic [31:0] rd_mux;
  logic acc_req;
  logic en;
  logic mclk_d_ff;
  logic sh_d_ff;
  logic tick;
  logic sh_edge;
  logic [SINC_W-1:0] sinc_out [2];
  logic [1:0] sinc_stb;
  logic [1:0] sinc_ok;
  logic signed [ACC_W-1:0] acc_ff;
  logic signed [ACC_W-1:0] ihold_ff;
  logic signed [ACC_W-1:0] term;
  logic [7:0] icnt_ff;
  logic istb_ff;
  logic add_en;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] thold_ff;
  logic trip_hi;
  logic trip_lo;
  logic [3:0] ev;
  logic [9:0] tcnt_ff;

  assign en = ctrl_ff[CB_EN];
  assign hresp = 1'b0;
  assign hreadyout = (st_ff != ITO_RD1);
  assign acc_req = hsel && (htrans == HTRANS_NSQ) && hready;

  // Bus phase tracking; a read waits one cycle so hrdata comes from a flop.
  always_comb begin
    nxt_st = ITO_IDLE;
    unique case (st_ff)
      ITO_RD1: nxt_st = ITO_RD2;
      ITO_IDLE, ITO_RD2: nxt_st = (acc_req && !hwrite) ? ITO_RD1 : ITO_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= ITO_IDLE;
      wr_ff <= 1'b0;
      daddr_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      if (st_ff != ITO_RD1) begin
        wr_ff <= acc_req && hwrite;
        if (acc_req) begin
          daddr_ff <= haddr[7:0];
        end
      end
    end
  end

  always_comb begin
    case (daddr_ff)
      OFF_CTRL: rd_mux = 32'(ctrl_ff);
      OFF_SINC_DECIMATION_RATIO: rd_mux = 32'(sinc_decimation_ratio_ff);
      OFF_INTEGRATOR_DECIMATION_RATIO: rd_mux = 32'(integrator_decimation_ratio_ff);
      OFF_COSR: rd_mux = 32'(cosr_ff);
      OFF_UPPER: rd_mux = 32'(upper_ff);
      OFF_LOWER: rd_mux = 32'(lower_ff);
      OFF_DATA: rd_mux = 32'(sinc_out[0]);
      OFF_IHOLD: rd_mux = 32'(ihold_ff);
      OFF_THOLD: rd_mux = 32'(thold_ff);
      OFF_CMP: rd_mux = 32'(sinc_out[1]);
      OFF_STATUS: rd_mux = 32'(status_ff);
      OFF_MASK: rd_mux = 32'(mask_ff);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (st_ff == ITO_RD1) begin
      hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= RST_CTRL;
      sinc_decimation_ratio_ff <= RST_SINC_DECIMATION_RATIO;
      integrator_decimation_ratio_ff <= RST_INTEGRATOR_DECIMATION_RATIO;
      cosr_ff <= RST_COSR;
      upper_ff <= RST_UPPER;
      lower_ff <= RST_LOWER;
      mask_ff <= RST_MASK;
    end else if (wr_ff) begin
      case (daddr_ff)
        OFF_CTRL: ctrl_ff <= hwdata[3:0];
        OFF_SINC_DECIMATION_RATIO: sinc_decimation_ratio_ff <= hwdata[7:0];
        OFF_INTEGRATOR_DECIMATION_RATIO: integrator_decimation_ratio_ff <= hwdata[7:0];
        OFF_COSR: cosr_ff <= hwdata[7:0];
        OFF_UPPER: upper_ff <= hwdata[15:0];
        OFF_LOWER: lower_ff <= hwdata[15:0];
        OFF_MASK: mask_ff <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // Read clears status; an event in the same cycle survives the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= 4'h0;
    end else if (st_ff == ITO_RD1 && daddr_ff == OFF_STATUS) begin
      status_ff <= ev;
    end else begin
      status_ff <= status_ff | ev;
    end
  end

  assign irq = |(status_ff & mask_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mclk_d_ff <= 1'b0;
      sh_d_ff <= 1'b0;
    end else begin
      mclk_d_ff <= modulator_clock_input;
      sh_d_ff <= sample_hold_input;
    end
  end

  assign tick = en && modulator_clock_input && !mclk_d_ff;
  assign sh_edge = en && sample_hold_input && !sh_d_ff;

  // Entry 0 is the data filter, entry 1 the comparator filter.
  for (genvar g = 0; g < 2; g++) begin : g_sinc
    logic [SINC_W-1:0] i1_ff, i2_ff, p2_ff, pd_ff, out_ff;
    logic [SINC_W-1:0] nxt_i1, nxt_i2, nxt_d1;
    logic [7:0] dec_ff;
    logic [7:0] rm1;
    logic [1:0] cnt_ff;
    logic stb_ff;
    assign rm1 = (g == 0) ? sinc_decimation_ratio_ff : cosr_ff;
    assign nxt_i1 = i1_ff + SINC_W'(modulator_bit_input);
    assign nxt_i2 = i2_ff + nxt_i1;
    assign nxt_d1 = nxt_i2 - p2_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        {i1_ff, i2_ff, p2_ff, pd_ff, out_ff} <= '0;
        dec_ff <= 8'h00;
        cnt_ff <= 2'h0;
        stb_ff <= 1'b0;
      end else if (!en) begin
        {i1_ff, i2_ff, p2_ff, pd_ff, out_ff} <= '0;
        dec_ff <= 8'h00;
        cnt_ff <= 2'h0;
        stb_ff <= 1'b0;
      end else begin
        stb_ff <= 1'b0;
        if (tick) begin
          i1_ff <= nxt_i1;
          i2_ff <= nxt_i2;
          if (dec_ff == rm1) begin
            dec_ff <= 8'h00;
            p2_ff <= nxt_i2;
            pd_ff <= nxt_d1;
            out_ff <= nxt_d1 - pd_ff;
            stb_ff <= 1'b1;
            // Output counts as settled after order decimations.
            if (cnt_ff != SINC_ORDER) begin
              cnt_ff <= cnt_ff + 2'h1;
            end
          end else begin
            dec_ff <= dec_ff + 8'h01;
          end
        end
      end
    end
    assign sinc_out[g] = out_ff;
    assign sinc_stb[g] = stb_ff;
    assign sinc_ok[g] = (cnt_ff == SINC_ORDER);
  end

  // Bypass feeds raw bits as +1/-1; otherwise settled sinc words.
  assign term = ctrl_ff[CB_BYP] ?
    (modulator_bit_input ? ACC_W'(1) : {ACC_W{1'b1}}) :
    $signed(ACC_W'(sinc_out[0]));
  assign add_en = ctrl_ff[CB_BYP] ? tick : (sinc_stb[0] && sinc_ok[0]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= '0;
      ihold_ff <= '0;
      icnt_ff <= 8'h00;
      istb_ff <= 1'b0;
    end else begin
      istb_ff <= 1'b0;
      if (!en) begin
        acc_ff <= '0;
        icnt_ff <= 8'h00;
      end else if (ctrl_ff[CB_INTEGRATOR_MODE_SELECT]) begin
        if (sh_edge) begin
          ihold_ff <= acc_ff;
          acc_ff <= add_en ? term : '0;
          istb_ff <= 1'b1;
        end else if (add_en) begin
          acc_ff <= acc_ff + term;
        end
      end else if (add_en) begin
        if (icnt_ff == integrator_decimation_ratio_ff) begin
          ihold_ff <= acc_ff + term;
          acc_ff <= '0;
          icnt_ff <= 8'h00;
          istb_ff <= 1'b1;
        end else begin
          acc_ff <= acc_ff + term;
          icnt_ff <= icnt_ff + 8'h01;
        end
      end
    end
  end

  // Timer saturates rather than wrapping, so a stalled edge stays visible.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_ff <= '0;
      thold_ff <= '0;
    end else if (!en || !ctrl_ff[CB_TM]) begin
      tmr_ff <= '0;
    end else if (sh_edge) begin
      thold_ff <= tmr_ff;
      tmr_ff <= tick ? TMR_W'(1) : '0;
    end else if (tick && tmr_ff != '1) begin
      tmr_ff <= tmr_ff + TMR_W'(1);
    end
  end

  assign trip_hi = sinc_out[1] > SINC_W'(upper_ff);
  assign trip_lo = sinc_out[1] < SINC_W'(lower_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overcurrent_flag <= 1'b0;
    end else if (!en) begin
      overcurrent_flag <= 1'b0;
    end else if (sinc_stb[1] && sinc_ok[1]) begin
      overcurrent_flag <= trip_hi || trip_lo;
    end
  end

  assign ev[SB_DATA] = sinc_stb[0] && sinc_ok[0];
  assign ev[SB_INT] = istb_ff;
  assign ev[SB_HI] = sinc_stb[1] && sinc_ok[1] && trip_hi;
  assign ev[SB_LO] = sinc_stb[1] && sinc_ok[1] && trip_lo;

  // Helper for checks only: modulator ticks since enable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcnt_ff <= 10'h000;
    end else if (!en) begin
      tcnt_ff <= 10'h000;
    end else if (tick && tcnt_ff != 10'h3FF) begin
      tcnt_ff <= tcnt_ff + 10'h001;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_sh_int_latch: assert property (
    ctrl_ff[CB_INTEGRATOR_MODE_SELECT] && sh_edge |=> ihold_ff == $past(acc_ff) && istb_ff)
    else $error("integrator not latched on sample-hold edge");
  a_sh_tmr_latch: assert property (
    ctrl_ff[CB_TM] && sh_edge |=> thold_ff == $past(tmr_ff) && tmr_ff <= TMR_W'(1))
    else $error("timer not latched and restarted");
  a_sh_hold_idle: assert property (
    ctrl_ff[CB_INTEGRATOR_MODE_SELECT] && !sh_edge |=> $stable(ihold_ff) && !istb_ff)
    else $error("integrator dumped without sample-hold edge");
  a_cascade_sum: assert property (
    en && ctrl_ff[CB_INTEGRATOR_MODE_SELECT] && !ctrl_ff[CB_BYP] && !sh_edge && add_en
    |=> acc_ff == $past(acc_ff) + $signed(ACC_W'($past(sinc_out[0]))))
    else $error("cascade sum wrong");
  a_bypass_step: assert property (
    en && ctrl_ff[CB_INTEGRATOR_MODE_SELECT] && ctrl_ff[CB_BYP] && tick && !sh_edge
    |=> acc_ff - $past(acc_ff) == ($past(modulator_bit_input) ? ACC_W'(1) : {ACC_W{1'b1}}))
    else $error("bypass step is not plus or minus one");
  a_settle_time: assert property (
    en && $rose(sinc_ok[0]) |-> tcnt_ff == 10'(2 * (32'(sinc_decimation_ratio_ff) + 1)))
    else $error("data filter settled at wrong tick count");
  a_cmp_span: assert property (
    sinc_ok[1] |-> 32'(sinc_out[1]) <= (32'(cosr_ff) + 1) * (32'(cosr_ff) + 1))
    else $error("comparator output beyond ratio squared");
  a_trip_window: assert property (
    sinc_stb[1] && sinc_ok[1] |=> overcurrent_flag == $past(trip_hi || trip_lo)
    ##1 overcurrent_flag == $past(overcurrent_flag) || $past(sinc_stb[1]))
    else $error("over-current flag does not follow window");
  a_timer_count: assert property (
    ctrl_ff[CB_TM] && tick && !sh_edge && tmr_ff != '1 |=> tmr_ff == $past(tmr_ff) + 1'b1)
    else $error("timer missed a modulator clock");
  a_irq_level: assert property (
    ev[SB_HI] && mask_ff[SB_HI] |=> irq[*2])
    else $error("masked-in trip did not raise interrupt");

  c_sh_cycle: cover property (ctrl_ff[CB_TM] && ctrl_ff[CB_INTEGRATOR_MODE_SELECT] && sh_edge && tmr_ff > 2);
  c_trip: cover property ($rose(overcurrent_flag));
  c_bypass: cover property (ctrl_ff[CB_BYP] && istb_ff);
  c_status_rd: cover property (st_ff == ITO_RD1 && daddr_ff == OFF_STATUS && irq);
endmodule : ito_top
`default_nettype wire

// File: tb/ito_mod_model.sv
// Purpose: Modulator stand-in driving the clock and bit pins.
// Assumes: Four hclk cycles per modulator period.
// Notes: Clock rests low between bursts; the bit shows its inverse while low.
`timescale 1ns/1ps
`default_nettype none
module ito_mod_model (
  // Bus clock.
  input wire logic hclk,
  // Modulator pins.
  output logic mclk,
  output logic mbit
);
  initial begin
    mclk = 1'b0;
    mbit = 1'b0;
  end
  // Pattern 0 is all low, 1 all high, 2 alternating from low.
  task automatic burst(input int n, input int pat);
    logic v;
    for (int i = 0; i < n; i++) begin
      v = (pat == 2) ? i[0] : pat[0];
      repeat (2) @(posedge hclk);
      mclk <= 1'b1;
      mbit <= v;
      repeat (2) @(posedge hclk);
      mclk <= 1'b0;
      // The inverse makes a design that samples outside the rise visible.
      mbit <= ~v;
    end
  endtask : burst
endmodule : ito_mod_model
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the filter channel.
// Assumes: Single AHB-Lite master, hready tied to hreadyout.
// Notes: Bursts end before each sample-hold pulse so no tick coincides.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ito_pkg::*;
  logic hclk, hresetn, hsel, hwrite, sh;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_s;
  logic hreadyout, hresp, mclk, mbit, ocf, irq;
  int bad_count, total_checks;
  ito_top ito_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .modulator_clock_input(mclk),
    .modulator_bit_input(mbit), .sample_hold_input(sh), .overcurrent_flag(ocf), .irq(irq));
  ito_mod_model ito_mod_model_i (.hclk(hclk), .mclk(mclk), .mbit(mbit));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  // Ready is looked at on the falling edge, where it already holds its sampled value.
  task automatic wait_rdy();
    for (int n = 0; n < 50; n++) begin
      @(negedge hclk);
      rd_s = hrdata;
      if (hreadyout === 1'b1) begin
        @(posedge hclk);
        return;
      end
      @(posedge hclk);
    end
    bad_count++;
    end_sim();
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NSQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd_s, e);
  endtask : rdc
  task automatic pulse();
    @(posedge hclk);
    sh <= 1'b1;
    repeat (2) @(posedge hclk);
    sh <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : pulse
  task automatic t_reset();
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_SINC_DECIMATION_RATIO, {24'h0, RST_SINC_DECIMATION_RATIO});
    rdc(OFF_INTEGRATOR_DECIMATION_RATIO, {24'h0, RST_INTEGRATOR_DECIMATION_RATIO});
    rdc(OFF_UPPER, {16'h0, RST_UPPER});
    rdc(OFF_LOWER, 32'h0);
    rdc(OFF_MASK, 32'h0);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    chk_bit(hresp, 1'b0);
    chk_bit(irq, 1'b0);
    chk_bit(ocf, 1'b0);
  endtask : t_reset
  task automatic t_bypass();
    ahb(1'b1, OFF_CTRL, 32'hF);
    pulse();
    for (int p = 0; p < 3; p++) begin
      ito_mod_model_i.burst(20, p);
      pulse();
      rdc(OFF_IHOLD, (p == 2) ? 32'h0 : (p == 1) ? 32'd20 : 32'hFFFF_FFEC);
      rdc(OFF_THOLD, 32'd20);
    end
    pulse();
    rdc(OFF_IHOLD, 32'h0);
    rdc(OFF_THOLD, 32'h0);
  endtask : t_bypass
  task automatic t_irq();
    ahb(1'b1, OFF_MASK, 32'h1 << SB_INT);
    ahb(1'b0, OFF_STATUS, 32'h0);
    pulse();
    chk_bit(irq, 1'b1);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk_bit(rd_s[SB_INT], 1'b1);
    @(negedge hclk);
    chk_bit(irq, 1'b0);
    ahb(1'b1, OFF_MASK, 32'h0);
    pulse();
    @(negedge hclk);
    chk_bit(irq, 1'b0);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk_bit(rd_s[SB_INT], 1'b1);
  endtask : t_irq
  task automatic t_trip();
    int p;
    ahb(1'b1, OFF_CTRL, 32'h0);
    ahb(1'b1, OFF_UPPER, 32'd192);
    ahb(1'b1, OFF_LOWER, 32'd64);
    ahb(1'b1, OFF_MASK, 32'h1 << SB_HI);
    ahb(1'b1, OFF_CTRL, 32'h1);
    ahb(1'b0, OFF_STATUS, 32'h0);
    ito_mod_model_i.burst(16, 1);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk_bit(rd_s[SB_DATA], 1'b0);
    ito_mod_model_i.burst(16, 1);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk_bit(rd_s[SB_DATA], 1'b1);
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 1 : (k == 1) ? 0 : 2;
      ito_mod_model_i.burst(48, p);
      rdc(OFF_CMP, (p == 1) ? 32'h100 : (p == 0) ? 32'h0 : 32'h80);
      chk_bit(ocf, p != 2);
      if (k == 0) begin
        chk_bit(irq, 1'b1);
      end
    end
    rdc(OFF_DATA, 32'h80);
    ahb(1'b0, OFF_STATUS, 32'h0);
    chk_bit(rd_s[SB_HI], 1'b1);
    chk_bit(rd_s[SB_LO], 1'b1);
    chk_bit(irq, 1'b0);
  endtask : t_trip
  task automatic t_cascade();
    ahb(1'b1, OFF_CTRL, 32'h7);
    ito_mod_model_i.burst(32, 1);
    pulse();
    ito_mod_model_i.burst(64, 1);
    pulse();
    rdc(OFF_IHOLD, 32'd1024);
    rdc(OFF_THOLD, 32'd64);
  endtask : t_cascade
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sh = 1'b0;
    bad_count = 0;
    total_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_bypass();
    t_irq();
    t_trip();
    t_cascade();
    end_sim();
  end
endmodule : tb
`default_nettype wire
